// [common/scm_pkg.sv]
// constants and types for the system clock and power mode control block
// assumes one 100 MHz clock and a plain single-cycle register port
package scm_pkg;
   // register indexes on the register port
   localparam logic [2:0] ADDR_MODE_CTRL = 3'h0;
   localparam logic [2:0] ADDR_AUX_CTRL  = 3'h1;
   localparam logic [2:0] ADDR_IRQ_STAT  = 3'h2;
   localparam logic [2:0] ADDR_IRQ_CLR   = 3'h3;
   localparam logic [2:0] ADDR_IRQ_EN    = 3'h4;
   // system_clock_mode_control fields
   localparam int         MC_DIV_LSB  = 5;
   localparam int         MC_FAST     = 4;
   localparam int         MC_LO_RDY   = 3;
   localparam int         MC_HI_RDY   = 2;
   localparam int         MC_IDLE     = 1;
   localparam int         MC_HL       = 0;
   localparam logic [7:0] MC_RESET    = 8'h03;
   localparam logic [7:0] MC_WR_MASK  = 8'hf3;
   // auxiliary control fields
   localparam int         AUX_HOLD    = 0;
   localparam int         AUX_LVD     = 1;
   localparam int         AUX_WDT     = 2;
   localparam logic [2:0] AUX_RESET   = 3'h0;
   // interrupt bit positions
   localparam int         IRQ_HI_RDY  = 0;
   localparam int         IRQ_LO_RDY  = 1;
   localparam int         IRQ_WAKE    = 2;
   localparam int         IRQ_W       = 3;
   // oscillator settle counts, in oscillator cycles
   localparam logic [9:0] HI_XTAL_CYC = 10'h200;
   localparam logic [9:0] HI_RC_CYC   = 10'h010;
   localparam logic [9:0] LO_XTAL_CYC = 10'h080;
   localparam logic [9:0] LO_RC_CYC   = 10'h002;
   // first divider code for the high-speed clock, and the largest divide exponent
   localparam logic [2:0] DIV_FIRST_HI = 3'h2;
   localparam logic [2:0] DIV_MAX_LOG2 = 3'h6;
   // operating modes
   typedef enum logic [2:0] {
      MODE_RUN, MODE_DEEP_SLEEP_MODE, MODE_SLEEP_WITH_SUBSTITUTE_CLOCK, MODE_IDLE_CLOCK_STOPPED, MODE_IDLE_CLOCK_RUNNING, MODE_WAKE
   } scm_mode_t;
   // clock gate bundle driven out to the clock tree
   typedef struct packed {
      logic cpu;    // cpu clock running
      logic sys;    // system clock running
      logic sub;    // substitute clock running
      logic per;    // peripheral slow clock running
      logic tbc;    // time-base clock running
      logic hiOsc;  // high-speed oscillator enabled
      logic loOsc;  // low-speed oscillator enabled
   } scm_gates_t;
endpackage : scm_pkg

// [rtl/scm_top.sv]
// system clock selection and halted power mode control
// assumes oscillator outputs arrive as slow async levels on pins,
// halt requests come from the cpu on clk, wake requests from pins
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - gate clocks per halted mode
// - high-speed mode divides oscillator by 1..64
// - divider code picks substitute or fH/64..fH/2
// - high/low select one uses undivided fH
// - high-speed oscillator off while on substitute
// - halt enters idle or sleep, cpu stops
// - deep sleep only without lvd and watchdog
// - lvd or watchdog gives sleep with substitute
// - idle with hold zero stops system clock
// - idle with hold one keeps system clock
// - low ready flag: 128 or 2 cycles
// - high ready flag: 512 or 16 cycles
// - fast wake runs substitute until crystal ready
// - fast wake only from sleep_with_substitute_clock and idle_clock_stopped
// - internal rc sources ignore fast wake
module scm_top (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [2:0]        regAddr,
   input  wire logic [7:0]        regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [7:0]        regRdata,
   input  wire logic              haltReq,
   input  wire logic              wakePin,
   input  wire logic              hiOscPin,
   input  wire logic              loOscPin,
   input  wire logic              hiIsXtalPin,
   input  wire logic              loIsXtalPin,
   output var scm_pkg::scm_gates_t gates,
   output logic                   sysTick,
   output logic                   wdtRun,
   output logic                   irq
);
   // synchroniser stages and edge history for pins
   logic [4:0] syncA;      // first stage, read only by syncB
   logic [4:0] syncB;      // second stage
   logic [1:0] tickHist;   // delayed oscillator levels
   logic       hiTick;     // one high-speed oscillator rising edge
   logic       loTick;     // one low-speed oscillator rising edge
   logic       wakeIn;     // synchronised wake level
   logic       hiIsXtal;   // high-speed source is crystal
   logic       loIsXtal;   // low-speed source is crystal

   // local constants through the package, declared before first use
   localparam int IRQ_W = scm_pkg::IRQ_W;
   localparam scm_pkg::scm_mode_t
      MODE_RUN    = scm_pkg::MODE_RUN,    MODE_WAKE   = scm_pkg::MODE_WAKE,
      MODE_DEEP_SLEEP_MODE = scm_pkg::MODE_DEEP_SLEEP_MODE, MODE_SLEEP_WITH_SUBSTITUTE_CLOCK = scm_pkg::MODE_SLEEP_WITH_SUBSTITUTE_CLOCK,
      MODE_IDLE_CLOCK_STOPPED  = scm_pkg::MODE_IDLE_CLOCK_STOPPED,  MODE_IDLE_CLOCK_RUNNING  = scm_pkg::MODE_IDLE_CLOCK_RUNNING;

   // software-visible state
   logic [7:0] modeCtrl;   // control register, flag bits unused
   logic [2:0] auxCtrl;    // hold, lvd enable, watchdog enable
   logic [IRQ_W-1:0] irqStat;
   logic [IRQ_W-1:0] irqEn;

   // clock and mode state
   scm_pkg::scm_mode_t mode;
   logic       actHigh;    // active source is high-speed
   logic [2:0] actDiv;     // active divide exponent
   logic [5:0] divCnt;     // high-speed edge counter
   logic [9:0] hiCnt;      // high-speed settle counter
   logic [9:0] loCnt;      // low-speed settle counter
   logic       hiReady;
   logic       loReady;
   logic       hiReadyD;   // for rise detection
   logic       loReadyD;
   logic       wakeDone;   // one-cycle wake completion
   logic       fastWake;   // fast wake chosen at halt exit

   // divide exponent from control bits, 0 means undivided
   function automatic logic [2:0] divLog2(input logic hl, input logic [2:0] code);
      if (hl)
         divLog2 = 3'h0;
      else
         divLog2 = scm_pkg::DIV_MAX_LOG2 - (code - scm_pkg::DIV_FIRST_HI);
   endfunction : divLog2

   // true when the divider counter closes one divided period
   function automatic logic divWrap(input logic [5:0] cnt, input logic [2:0] lg);
      logic [5:0] mask;
      mask = ~(6'h3f << lg);
      divWrap = ((cnt & mask) == mask);
   endfunction : divWrap

   // control bits decoded
   logic       wantHigh;
   logic [2:0] wantDiv;
   logic       oscHiOn;
   logic       oscLoOn;
   logic       fastOk;
   logic       curReady;

   assign wantHigh = modeCtrl[scm_pkg::MC_HL] ||
                     (modeCtrl[7:5] >= scm_pkg::DIV_FIRST_HI);
   assign wantDiv  = divLog2(modeCtrl[scm_pkg::MC_HL], modeCtrl[7:5]);
   assign curReady = actHigh ? hiReady : loReady;

   // high oscillator off once on substitute
   // stopped in idle_clock_stopped and both sleeps
   always_comb
   begin
      oscHiOn = 1'b0;
      case (mode)
         MODE_RUN:    oscHiOn = wantHigh || actHigh;
         MODE_IDLE_CLOCK_RUNNING:  oscHiOn = actHigh;
         MODE_WAKE:   oscHiOn = wantHigh || actHigh;
         default:     oscHiOn = 1'b0;
      endcase
   end

   // low oscillator runs except in deep sleep
   assign oscLoOn = (mode != MODE_DEEP_SLEEP_MODE);

   // fast wake only from sleep_with_substitute_clock or idle_clock_stopped
   // only a crystal high source uses it
   assign fastOk = modeCtrl[scm_pkg::MC_FAST] && hiIsXtal && actHigh &&
                   ((mode == MODE_SLEEP_WITH_SUBSTITUTE_CLOCK) || (mode == MODE_IDLE_CLOCK_STOPPED));

   // two-flop synchronisers for all pins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syncA <= 5'h00;
         syncB <= 5'h00;
      end
      else
      begin
         syncA <= {loIsXtalPin, hiIsXtalPin, wakePin, loOscPin, hiOscPin};
         syncB <= syncA;
      end
   end

   // edge history reads only the second stage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         tickHist <= 2'h0;
      else
         tickHist <= syncB[1:0];
   end

   // oscillator edges and straps from the second stage
   assign hiTick   = syncB[0] && !tickHist[0];
   assign loTick   = syncB[1] && !tickHist[1];
   assign wakeIn   = syncB[2];
   assign hiIsXtal = syncB[3];
   assign loIsXtal = syncB[4];

   // high ready after 512 crystal or 16 rc edges
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hiCnt   <= 10'h000;
         hiReady <= 1'b0;
      end
      else if (!oscHiOn)
      begin
         // cleared while stopped, restarts the settle count
         hiCnt   <= 10'h000;
         hiReady <= 1'b0;
      end
      else if (!hiReady && hiTick)
      begin
         hiCnt   <= hiCnt + 10'h001;
         hiReady <= (hiCnt + 10'h001) >=
                    (hiIsXtal ? scm_pkg::HI_XTAL_CYC : scm_pkg::HI_RC_CYC);
      end
   end

   // low ready after 128 crystal or 2 rc edges
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         loCnt   <= 10'h000;
         loReady <= 1'b0;
      end
      else if (!oscLoOn)
      begin
         // zero during deep sleep
         loCnt   <= 10'h000;
         loReady <= 1'b0;
      end
      else if (!loReady && loTick)
      begin
         loCnt   <= loCnt + 10'h001;
         loReady <= (loCnt + 10'h001) >=
                    (loIsXtal ? scm_pkg::LO_XTAL_CYC : scm_pkg::LO_RC_CYC);
      end
   end

   // high-speed edge counter for the divider
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         divCnt <= 6'h00;
      else if (hiTick)
         divCnt <= divCnt + 6'h01;
   end

   logic rawTick;
   assign rawTick = actHigh ? (hiTick && divWrap(divCnt, actDiv)) : loTick;

   // active source and divider
   // change at period end or while the current source is not ready, target ready; fast wake forces substitute
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         actHigh <= 1'b0;
         actDiv  <= 3'h0;
      end
      else if ((mode == MODE_WAKE) && fastWake)
         actHigh <= 1'b0;
      else if ((mode == MODE_RUN) && (rawTick || !curReady))
      begin
         // a stalled current source may be left at once
         if (wantHigh && hiReady)
         begin
            actHigh <= 1'b1;
            actDiv  <= wantDiv;
         end
         else if (!wantHigh && loReady)
            actHigh <= 1'b0;
      end
   end

   // fast wake choice latched at halt exit
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         fastWake <= 1'b0;
      else if (mode != MODE_WAKE && mode != MODE_RUN && wakeIn)
         fastWake <= fastOk;
      else if (mode == MODE_RUN)
         fastWake <= 1'b0;
   end

   // mode machine
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         mode <= MODE_RUN;
      else
      begin
         case (mode)
            MODE_RUN:
               if (haltReq)
               begin
                  if (modeCtrl[scm_pkg::MC_IDLE])
                     mode <= auxCtrl[scm_pkg::AUX_HOLD] ? MODE_IDLE_CLOCK_RUNNING : MODE_IDLE_CLOCK_STOPPED;
                  else if (auxCtrl[scm_pkg::AUX_LVD] || auxCtrl[scm_pkg::AUX_WDT])
                     mode <= MODE_SLEEP_WITH_SUBSTITUTE_CLOCK;
                  else
                     mode <= MODE_DEEP_SLEEP_MODE;
               end
            MODE_IDLE_CLOCK_RUNNING:
               // system clock kept, resumes at once
               if (wakeIn)
                  mode <= MODE_RUN;
            MODE_WAKE:
               // resume once the clock to run on is ready
               if (fastWake ? loReady : curReady)
                  mode <= MODE_RUN;
            default:
               if (wakeIn)
                  mode <= MODE_WAKE;
         endcase
      end
   end

   // wake completion pulse
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         wakeDone <= 1'b0;
      else
         wakeDone <= (mode != MODE_RUN) && (mode != MODE_DEEP_SLEEP_MODE) &&
                     (mode != MODE_SLEEP_WITH_SUBSTITUTE_CLOCK) && (mode != MODE_IDLE_CLOCK_STOPPED) && wakeIn &&
                     ((mode == MODE_IDLE_CLOCK_RUNNING) ||
                      (fastWake ? loReady : curReady));
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         gates <= '0;
      else
      begin
         gates.cpu   <= (mode == MODE_RUN);
         gates.sys   <= (mode == MODE_RUN) || (mode == MODE_IDLE_CLOCK_RUNNING);
         gates.sub   <= (mode != MODE_DEEP_SLEEP_MODE);
         gates.per   <= (mode != MODE_DEEP_SLEEP_MODE);
         gates.tbc   <= (mode != MODE_DEEP_SLEEP_MODE) && (mode != MODE_SLEEP_WITH_SUBSTITUTE_CLOCK);
         gates.hiOsc <= oscHiOn;
         gates.loOsc <= oscLoOn;
      end
   end

   // system tick only while the system clock runs
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sysTick <= 1'b0;
      else
         sysTick <= rawTick && curReady &&
                    ((mode == MODE_RUN) || (mode == MODE_IDLE_CLOCK_RUNNING));
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         wdtRun <= 1'b0;
      else
         wdtRun <= auxCtrl[scm_pkg::AUX_WDT] && (mode != MODE_DEEP_SLEEP_MODE);
   end

   // register writes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         modeCtrl <= scm_pkg::MC_RESET;
         auxCtrl  <= scm_pkg::AUX_RESET;
         irqEn    <= '0;
      end
      else if (regWr)
      begin
         if (regAddr == scm_pkg::ADDR_MODE_CTRL)
            modeCtrl <= regWdata & scm_pkg::MC_WR_MASK;
         else if (regAddr == scm_pkg::ADDR_AUX_CTRL)
            auxCtrl <= regWdata[2:0];
         else if (regAddr == scm_pkg::ADDR_IRQ_EN)
            irqEn <= regWdata[IRQ_W-1:0];
      end
   end

   // ready rise history
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hiReadyD <= 1'b0;
         loReadyD <= 1'b0;
      end
      else
      begin
         hiReadyD <= hiReady;
         loReadyD <= loReady;
      end
   end

   // sticky events, a new event wins over a clear
   logic [IRQ_W-1:0] irqSet;
   logic [IRQ_W-1:0] irqClr;
   assign irqSet = {wakeDone, loReady && !loReadyD, hiReady && !hiReadyD};
   assign irqClr = (regWr && (regAddr == scm_pkg::ADDR_IRQ_CLR)) ?
                   regWdata[IRQ_W-1:0] : '0;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irqStat <= '0;
      else
         irqStat <= (irqStat & ~irqClr) | irqSet;
   end

   // level interrupt, registered
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= |(irqStat & irqEn);
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         regRdata <= 8'h00;
      else if (!regRd)
         regRdata <= 8'h00;
      else if (regAddr == scm_pkg::ADDR_MODE_CTRL)
         regRdata <= {modeCtrl[7:4], loReady, hiReady, modeCtrl[1:0]};
      else if (regAddr == scm_pkg::ADDR_AUX_CTRL)
         regRdata <= {5'h00, auxCtrl};
      else if (regAddr == scm_pkg::ADDR_IRQ_STAT)
         regRdata <= {5'h00, irqStat};
      else if (regAddr == scm_pkg::ADDR_IRQ_EN)
         regRdata <= {5'h00, irqEn};
      else
         // clear register and unmapped read as zero
         regRdata <= 8'h00;
   end

endmodule : scm_top
`default_nettype wire

// [verif/scm_top_assertions.sv]
// port checker for the clock and power mode block
// assumes one clock domain and the scm_pkg register map
`timescale 1ns/1ps
`default_nettype none
module scm_top_assertions (
   input wire logic                clk,
   input wire logic                nrst,
   input wire logic [2:0]          regAddr,
   input wire logic [7:0]          regWdata,
   input wire logic                regWr,
   input wire logic                regRd,
   input wire logic [7:0]          regRdata,
   input wire logic                haltReq,
   input wire logic                wakePin,
   input wire logic                hiOscPin,
   input wire logic                loOscPin,
   input wire logic                hiIsXtalPin,
   input wire logic                loIsXtalPin,
   input wire scm_pkg::scm_gates_t gates,
   input wire logic                sysTick,
   input wire logic                wdtRun,
   input wire logic                irq
);
   logic [7:0] mc;      // writable mode control bits
   logic [2:0] aux;     // hold, lvd, watchdog copy
   logic       runHalt; // halt taken while running
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // shadows follow port writes, since internals are hidden
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mc  <= scm_pkg::MC_RESET & scm_pkg::MC_WR_MASK;
         aux <= scm_pkg::AUX_RESET;
      end
      else if (regWr && regAddr == scm_pkg::ADDR_MODE_CTRL)
         mc <= regWdata & scm_pkg::MC_WR_MASK;
      else if (regWr && regAddr == scm_pkg::ADDR_AUX_CTRL)
         aux <= regWdata[2:0];
   end
   // a running cpu shows the gate, halted ones do not
   assign runHalt = haltReq && gates.cpu;
   a_halt_stops_cpu: assert property (runHalt |-> ##2 !gates.cpu)
      else $error("cpu clock kept after halt");
   a_deep_sleep_gates: assert property (
      runHalt && !mc[1] && aux[2:1] == 2'b00 |-> ##2
      !gates.sys && !gates.sub && !gates.per && !gates.tbc && !wdtRun)
      else $error("deep sleep left a clock running");
   a_sleep_sub_gates: assert property (
      runHalt && !mc[1] && aux[2:1] != 2'b00 |-> ##2
      !gates.sys && gates.sub && gates.per && !gates.tbc)
      else $error("sleep with substitute gates wrong");
   a_idle_stop_gates: assert property (
      runHalt && mc[1] && !aux[0] |-> ##2
      !gates.sys && !gates.hiOsc && gates.sub && gates.per && gates.tbc)
      else $error("idle with stopped clock gates wrong");
   a_idle_run_gates: assert property (
      runHalt && mc[1] && aux[0] |-> ##2
      gates.sys && gates.sub && gates.per && gates.tbc)
      else $error("idle with running clock gates wrong");
   a_read_data_idle: assert property (!regRd |=> regRdata == 8'h00)
      else $error("read data outside a read cycle");
   a_mode_readback: assert property (
      regRd && regAddr == scm_pkg::ADDR_MODE_CTRL |=>
      (regRdata & scm_pkg::MC_WR_MASK) == $past(mc))
      else $error("mode control readback wrong");
   a_hi_rdy_halted: assert property (
      regRd && regAddr == 3'h0 && !gates.cpu && !gates.sys && !wakePin
      |=> !regRdata[scm_pkg::MC_HI_RDY])
      else $error("high ready flag set while halted");
   a_lo_rdy_deep: assert property (
      regRd && regAddr == 3'h0 && !gates.sub && !wakePin
      |=> !regRdata[scm_pkg::MC_LO_RDY])
      else $error("low ready flag set in deep sleep");
endmodule : scm_top_assertions
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the clock and power mode block
// starts on internal rc straps, later crystal straps; oscillators well below clk/4
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
   logic                clk = 1'b0;      // 100 MHz clock
   logic                nrst = 1'b0;     // active low reset
   logic [2:0]          regAddr = 3'h0;  // register index
   logic [7:0]          regWdata = 8'h00;
   logic                regWr = 1'b0;
   logic                regRd = 1'b0;
   logic [7:0]          regRdata;
   logic                haltReq = 1'b0;  // halt pulse
   logic                wakePin = 1'b0;  // wake level
   logic                hiOscPin = 1'b0; // 80 ns period
   logic                loOscPin = 1'b0; // 200 ns period
   logic                xtal = 1'b0;     // both straps, 1 = crystal
   scm_pkg::scm_gates_t gates;
   logic                sysTick;
   logic                wdtRun;
   logic                irq;
   int                  miscompares = 0;
   int                  comparisons = 0;
   int                  seed = 32'h56dd;
   int                  n, t0, cnt, ex;
   int                  tickCnt = 0;     // running tick total
   logic [31:0]         v;
   logic [7:0]          rdv;             // last read data
   logic [7:0]          model [0:7];     // register model
   logic [3:0]          cases [5] = '{4'b0000, 4'b0010, 4'b0001, 4'b1000, 4'b1100};
   always #5 clk = ~clk;
   always #40 hiOscPin = ~hiOscPin;
   always #100 loOscPin = ~loOscPin;
   // counted on the edge so sampling never races
   always @(posedge clk) tickCnt <= tickCnt + int'(sysTick);
   scm_top u_scm_top (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .haltReq(haltReq),
      .wakePin(wakePin), .hiOscPin(hiOscPin), .loOscPin(loOscPin), .hiIsXtalPin(xtal),
      .loIsXtalPin(xtal), .gates(gates), .sysTick(sysTick), .wdtRun(wdtRun), .irq(irq));
   function automatic logic [7:0] rmask(input logic [2:0] a);
      if (a == scm_pkg::ADDR_MODE_CTRL) return scm_pkg::MC_WR_MASK;
      if (a == scm_pkg::ADDR_AUX_CTRL || a == scm_pkg::ADDR_IRQ_EN) return 8'h07;
      return 8'hff;
   endfunction : rmask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      if (a < 2 || a == 4) model[a] = d & rmask(a);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [2:0] a);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdata;
      @(posedge clk);
   endtask : rd
   task automatic chk_reg(input logic [2:0] a);
      rd(a);
      `CHK("register", model[a], rdv & rmask(a))
   endtask : chk_reg
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      #1 `CHK("irq", e, irq)
      @(posedge clk);
   endtask : irq_chk
   // halt with {idle, hold, lvd, watchdog} and fast wake f, check gates, then wake
   task automatic halt(input logic [3:0] c, input logic f);
      logic [4:0] eg;
      eg = c[3] ? (c[2] ? 5'b01111 : 5'b00111) : (c[1] || c[0] ? 5'b00110 : 5'b00000);
      wr(scm_pkg::ADDR_AUX_CTRL, {5'h0, c[0], c[1], c[2]});
      wr(scm_pkg::ADDR_MODE_CTRL, {3'h0, f, 2'h0, c[3], 1'b1});
      haltReq <= 1'b1;
      @(posedge clk);
      haltReq <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK("gates", eg, {gates.cpu, gates.sys, gates.sub, gates.per, gates.tbc})
      `CHK("wdtRun", c[0], wdtRun)
      `CHK("loOsc", eg[2], gates.loOsc)
      @(posedge clk);
      rd(scm_pkg::ADDR_MODE_CTRL);
      if (c[3:2] != 2'b11) `CHK("hiReady", 1'b0, rdv[2])
      if (eg == 5'b00000) `CHK("loReady", 1'b0, rdv[3])
      wakePin <= 1'b1;
      for (n = 0; n < 3000 && gates.cpu !== 1'b1; n++) @(posedge clk);
      #1 `CHK("woken", 1'b1, gates.cpu)
      @(posedge clk);
      wakePin <= 1'b0;
   endtask : halt
   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // hang guard, well past the expected run length
   initial
   begin
      #500000;
      miscompares++;
      conclude();
   end
   initial
   begin
      for (int i = 0; i < 8; i++) model[i] = 8'h00;
      model[0] = scm_pkg::MC_RESET & scm_pkg::MC_WR_MASK;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) if (i != 2) chk_reg(3'(i));
      // random writes, unmapped places included
      repeat (12)
      begin
         v = $random(seed);
         wr(v[10:8], v[7:0]);
         if (v[10:8] != scm_pkg::ADDR_IRQ_STAT) chk_reg(v[10:8]);
      end
      wr(scm_pkg::ADDR_IRQ_EN, 8'h01 << scm_pkg::IRQ_WAKE);
      foreach (cases[k]) halt(cases[k], 1'b0);
      irq_chk(1'b1);
      wr(scm_pkg::ADDR_IRQ_EN, 8'h00);
      irq_chk(1'b0);
      wr(scm_pkg::ADDR_IRQ_EN, 8'h04);
      irq_chk(1'b1);
      wr(scm_pkg::ADDR_IRQ_CLR, 8'h04);
      irq_chk(1'b0);
      rd(scm_pkg::ADDR_IRQ_STAT);
      `CHK("wakeStatus", 1'b0, rdv[2])
      // every divider code, then the undivided clock
      for (int c = 0; c < 9; c++)
      begin
         wr(scm_pkg::ADDR_MODE_CTRL, c < 8 ? {3'(c), 5'h00} : 8'h01);
         repeat (600) @(posedge clk);
         t0 = tickCnt;
         repeat (2048) @(posedge clk);
         cnt = tickCnt - t0;
         ex = c < 2 ? 2048 / 20 : (c == 8 ? 256 : 2048 / (8 << (8 - c)));
         if (cnt >= ex - 2 && cnt <= ex + 2) cnt = ex;
         `CHK("ticks", ex, cnt)
         if (c < 2) `CHK("hiOsc", 1'b0, gates.hiOsc)
      end
      rd(scm_pkg::ADDR_MODE_CTRL);
      `CHK("readyFlags", 2'b11, rdv[3:2])
      // second reset with crystal straps: settle counts, then a fast wake
      nrst <= 1'b0;
      xtal <= 1'b1;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (2400) @(posedge clk);
      rd(scm_pkg::ADDR_MODE_CTRL);
      `CHK("loXtalEarly", 2'b00, rdv[3:2])
      repeat (400) @(posedge clk);
      rd(scm_pkg::ADDR_MODE_CTRL);
      `CHK("loXtalReady", 2'b10, rdv[3:2])
      repeat (1100) @(posedge clk);
      rd(scm_pkg::ADDR_MODE_CTRL);
      `CHK("hiXtalEarly", 2'b10, rdv[3:2])
      repeat (400) @(posedge clk);
      rd(scm_pkg::ADDR_MODE_CTRL);
      `CHK("hiXtalReady", 2'b11, rdv[3:2])
      // idle_clock_stopped on the crystal with fast wake: back long before 512 edges
      halt(4'b1000, 1'b1);
      `CHK("fastWakeTime", 1'b1, n < 20)
      rd(scm_pkg::ADDR_MODE_CTRL);
      `CHK("hiAfterFast", 1'b0, rdv[2])
      conclude();
   end
endmodule : tb
bind scm_top scm_top_assertions u_scm_top_assertions (.clk(clk), .nrst(nrst),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .haltReq(haltReq), .wakePin(wakePin), .hiOscPin(hiOscPin),
   .loOscPin(loOscPin), .hiIsXtalPin(hiIsXtalPin), .loIsXtalPin(loIsXtalPin),
   .gates(gates), .sysTick(sysTick), .wdtRun(wdtRun), .irq(irq));
`default_nettype wire
